// ---- arr_map.vh ----
`ifndef ARR_MAP_VH
`define ARR_MAP_VH
// ==========================================
// byte addresses
`define ARR_BUS_LO     8'h26
`define ARR_BUS_HI     8'h27
`define ARR_BAT_LO     8'h28
`define ARR_BAT_HI     8'h29
`define ARR_ADP_LO     8'h2a
`define ARR_ADP_HI     8'h2b
`define ARR_SYS_LO     8'h2c
`define ARR_SYS_HI     8'h2d
// ==========================================
// reset values and clamps
`define ARR_RESET_VAL  16'h0000
`define ARR_POS_MAX    16'h7fff
`define ARR_UNMAPPED   8'h00
// ==========================================
// field positions and channel options
`define ARR_SIGN_BIT   15
`define ARR_CLAMP_MASK 4'h9
`endif

// ---- arr_adc_result_registers.v ----
`timescale 1ns/100ps
`include "arr_map.vh"
// How it works
// - bus voltage is 16-bit, 2 mV step, negative codes clamp to zero.
// - one bus voltage sample stored when bus is present before converter starts.
// - battery current is signed 16-bit, 1 mA step, full range.
// - battery-only/OTG keeps only discharge; charge kept only with valid adapter.
// - adapter current positive forward, negative when flowing back to adapter.
// - adapter current is signed 16-bit, 0.5 mA step, full range.
// - each result is two bytes, low byte even address, high odd.
// - system rail voltage at 2Ch/2Dh, 2 mV step, clamped at zero.
// - battery current at 28h/29h, read only, resets to zero.
// - adapter current at 2Ah/2Bh, read only, resets to zero.
module arr_adc_result_registers (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        clkEn,
  input  wire        softReset,
  input  wire        busVoltageValid,
  input  wire [15:0] busVoltageSample,
  input  wire        converterRunning,
  input  wire        busPresent,
  input  wire        batteryCurrentValid,
  input  wire [15:0] batteryCurrentSample,
  input  wire        adapterValid,
  input  wire        adapterCurrentValid,
  input  wire [15:0] adapterCurrentSample,
  input  wire        systemRailValid,
  input  wire [15:0] systemRailSample,
  input  wire [7:0]  regAddr,
  input  wire        regRead,
  input  wire        regWrite,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata
);

  // ==========================================
  // pin synchronisers for status levels
  // pin levels need two enabled edges before they act
  localparam NPIN    = 3;
  localparam PIN_BUS = 0;
  localparam PIN_ADP = 1;
  localparam PIN_RUN = 2;

  wire [NPIN-1:0] pinRaw;
  wire [NPIN-1:0] pinSync;

  assign pinRaw[PIN_BUS] = busPresent;
  assign pinRaw[PIN_ADP] = adapterValid;
  assign pinRaw[PIN_RUN] = converterRunning;

  genvar pin;
  generate
    for (pin = 0; pin < NPIN; pin = pin + 1) begin : g_sync
      reg metaStage;
      reg syncStage;
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          metaStage <= 1'b0;
          syncStage <= 1'b0;
        end else if (clkEn) begin
          metaStage <= pinRaw[pin];
          syncStage <= metaStage;
        end
      end
      // only the second stage is read by logic
      assign pinSync[pin] = syncStage;
    end
  endgenerate

  wire busPresentS   = pinSync[PIN_BUS];
  wire adapterValidS = pinSync[PIN_ADP];
  wire convRunS      = pinSync[PIN_RUN];

  // ==========================================
  // channel numbering
  localparam NCH    = 4;
  localparam CH_BUS = 0;
  localparam CH_BAT = 1;
  localparam CH_ADP = 2;
  localparam CH_SYS = 3;

  // ==========================================
  // channel input bundles
  wire [NCH-1:0]    chValid;
  wire [16*NCH-1:0] chSample;
  wire [NCH-1:0]    chGate;
  wire [NCH-1:0]    chClampLow;
  wire [16*NCH-1:0] chStored;

  assign chValid[CH_BUS] = busVoltageValid;
  assign chValid[CH_BAT] = batteryCurrentValid;
  assign chValid[CH_ADP] = adapterCurrentValid;
  assign chValid[CH_SYS] = systemRailValid;

  assign chSample[16*CH_BUS +: 16] = busVoltageSample;
  assign chSample[16*CH_BAT +: 16] = batteryCurrentSample;
  assign chSample[16*CH_ADP +: 16] = adapterCurrentSample;
  assign chSample[16*CH_SYS +: 16] = systemRailSample;

  // voltages clamp negative codes, currents keep their sign
  assign chClampLow = `ARR_CLAMP_MASK;

  // ==========================================
  // acceptance gates
  reg  noLoadTaken;
  // charge (positive) only kept with a valid adapter
  wire batGate   = adapterValidS || batteryCurrentSample[`ARR_SIGN_BIT];
  // before start-up only the single no-load sample is kept
  wire busGate   = convRunS || (busPresentS && !noLoadTaken);
  wire busAccept = busVoltageValid && busGate;

  assign chGate[CH_BUS] = busGate;
  assign chGate[CH_BAT] = batGate;
  // adapter current keeps every sample, both signs
  assign chGate[CH_ADP] = 1'b1;
  assign chGate[CH_SYS] = 1'b1;

  // ==========================================
  // no-load sample latch, re-armed when the bus leaves
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      noLoadTaken <= 1'b0;
    end else if (clkEn) begin
      if (softReset || !busPresentS)
        noLoadTaken <= 1'b0;
      else if (busAccept && !convRunS)
        noLoadTaken <= 1'b1;
    end
  end

  // ==========================================
  // result storage, one slot per channel
  // soft reset outranks any sample arriving in the same cycle
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      reg  [15:0] stored;
      wire [15:0] raw     = chSample[16*ch +: 16];
      wire        isNeg   = raw[`ARR_SIGN_BIT];
      wire [15:0] clamped = (chClampLow[ch] && isNeg) ? `ARR_RESET_VAL : raw;
      wire        take    = chValid[ch] && chGate[ch];

      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          stored <= `ARR_RESET_VAL;
        end else if (clkEn) begin
          if (softReset)
            stored <= `ARR_RESET_VAL;
          else if (take)
            stored <= clamped;
        end
      end

      assign chStored[16*ch +: 16] = stored;
    end
  endgenerate

  // ==========================================
  // named result registers
  wire [15:0] bus_voltage_reading     = chStored[16*CH_BUS +: 16];
  wire [15:0] battery_current_reading = chStored[16*CH_BAT +: 16];
  wire [15:0] input_current_reading   = chStored[16*CH_ADP +: 16];
  wire [15:0] system_voltage_reading  = chStored[16*CH_SYS +: 16];

  // ==========================================
  // address decode, one lane per channel
  wire [8*NCH-1:0] laneLoAddr;
  wire [8*NCH-1:0] laneHiAddr;
  wire [NCH-1:0]   laneHit;
  wire [8*NCH-1:0] laneByte;

  assign laneLoAddr[8*CH_BUS +: 8] = `ARR_BUS_LO;
  assign laneLoAddr[8*CH_BAT +: 8] = `ARR_BAT_LO;
  assign laneLoAddr[8*CH_ADP +: 8] = `ARR_ADP_LO;
  assign laneLoAddr[8*CH_SYS +: 8] = `ARR_SYS_LO;
  // high byte sits at the odd address above its low byte
  assign laneHiAddr[8*CH_BUS +: 8] = `ARR_BUS_HI;
  assign laneHiAddr[8*CH_BAT +: 8] = `ARR_BAT_HI;
  assign laneHiAddr[8*CH_ADP +: 8] = `ARR_ADP_HI;
  assign laneHiAddr[8*CH_SYS +: 8] = `ARR_SYS_HI;

  genvar ln;
  generate
    for (ln = 0; ln < NCH; ln = ln + 1) begin : g_lane
      wire [15:0] word  = chStored[16*ln +: 16];
      wire        hitLo = (regAddr == laneLoAddr[8*ln +: 8]);
      wire        hitHi = (regAddr == laneHiAddr[8*ln +: 8]);

      assign laneHit[ln]         = hitLo || hitHi;
      assign laneByte[8*ln +: 8] = hitHi ? word[15:8] : word[7:0];
    end
  endgenerate

  // ==========================================
  // byte read port; unmapped addresses read as zero
  // lanes never overlap, so at most one hit
  reg [7:0] next_regRdata;
  integer   lane;
  always @* begin
    next_regRdata = `ARR_UNMAPPED;
    for (lane = 0; lane < NCH; lane = lane + 1) begin
      if (laneHit[lane])
        next_regRdata = laneByte[8*lane +: 8];
    end
  end

  // ==========================================
  // read data register; writes have no effect
  // holds until the next taken read
  wire readTaken = clkEn && regRead && !regWrite;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      regRdata <= `ARR_UNMAPPED;
    else if (readTaken)
      regRdata <= next_regRdata;
  end

endmodule // arr_adc_result_registers

// ---- arr_properties.sv ----
`timescale 1ns/100ps
// ====================
// read port checks
module arr_properties (
  input wire       mclk,
  input wire       arst_n,
  input wire       clkEn,
  input wire       softReset,
  input wire [7:0] regAddr,
  input wire       regRead,
  input wire       regWrite,
  input wire [7:0] regRdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_rd; clkEn && regRead && !regWrite; endsequence
  property p_hold; !(clkEn && regRead && !regWrite) |=> $stable(regRdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unm; s_rd ##0 (regAddr < 8'h26 || regAddr > 8'h2d) |=> regRdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_clr; clkEn && softReset ##1 s_rd |=> regRdata == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("soft reset left data");
  sequence s_hiByte; s_rd ##0 (regAddr == 8'h27 || regAddr == 8'h2d); endsequence
  property p_sign; s_hiByte |=> !regRdata[7]; endproperty
  a_sign: assert property (p_sign) else $error("voltage high byte negative");
  property p_wr; clkEn && regWrite |=> $stable(regRdata); endproperty
  a_wr: assert property (p_wr) else $error("write moved read data");
  property p_frz; !clkEn |=> $stable(regRdata); endproperty
  a_frz: assert property (p_frz) else $error("read data moved while frozen");
endmodule // arr_properties
bind arr_adc_result_registers arr_properties u_prop (.mclk(mclk), .arst_n(arst_n),
  .clkEn(clkEn), .softReset(softReset), .regAddr(regAddr), .regRead(regRead),
  .regWrite(regWrite), .regRdata(regRdata));

// ---- arr_host_model.sv ----
`timescale 1ns/100ps
// ====================
// host byte access
module arr_host_model (
  input  wire       mclk,
  output reg  [7:0] regAddr,
  output reg        regRead,
  output reg        regWrite
);
  initial regAddr = 8'h00;
  initial regRead = 1'b0;
  initial regWrite = 1'b0;
  task acc(input [7:0] a, input w);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRead <= ~w;
      regWrite <= w;
      @(posedge mclk);
      regRead <= 1'b0;
      regWrite <= 1'b0;
      regAddr <= ~a;
    end
  endtask
endmodule // arr_host_model

// ---- arr_adc_result_registers_tb.sv ----
`timescale 1ns/100ps
// ====================
// bench
module arr_adc_result_registers_tb;
  reg        mclk = 0, arst_n = 0, conv = 0, adpt = 0, srst = 0, vld = 0, got = 0;
  reg        en = 1, pres = 1;
  reg [15:0] smp [0:3];
  reg [15:0] v [0:3];
  reg [7:0]  wd = 0;
  reg [7:0]  q [$];
  wire [7:0] addr, rdata;
  wire       rd, wr;
  integer    seed = 59665, bad_count = 0, check_count = 0, cyc = 0, k;
  arr_host_model u_host (.mclk(mclk), .regAddr(addr), .regRead(rd), .regWrite(wr));
  arr_adc_result_registers u_dut (.mclk(mclk), .arst_n(arst_n), .clkEn(en), .softReset(srst),
    .busVoltageValid(vld), .busVoltageSample(smp[0]), .converterRunning(conv), .busPresent(pres),
    .batteryCurrentValid(vld), .batteryCurrentSample(smp[1]), .adapterValid(adpt),
    .adapterCurrentValid(vld), .adapterCurrentSample(smp[2]), .systemRailValid(vld),
    .systemRailSample(smp[3]), .regAddr(addr), .regRead(rd), .regWrite(wr), .regWdata(wd),
    .regRdata(rdata));
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    got <= rd & ~wr;
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  always @(negedge mclk) if (got) begin
    check_count = check_count + 1;
    if (rdata !== q[0]) begin
      bad_count = bad_count + 1;
      $display("[ERR] regRdata exp %h got %h", q[0], rdata);
    end
    q.pop_front();
  end
  task put(input [15:0] a, b, c, d);
    begin
      @(posedge mclk);
      smp[0] <= a; smp[1] <= b; smp[2] <= c; smp[3] <= d; vld <= 1;
      @(posedge mclk);
      vld <= 0;
    end
  endtask
  task chk(input [15:0] a, b, c, d);
    reg [63:0] e;
    begin
      e = {d, c, b, a};
      for (k = 0; k < 9; k = k + 1) begin
        q.push_back(k < 8 ? e[k*8 +: 8] : 8'h00);
        u_host.acc(k < 8 ? 8'h26 + k[7:0] : 8'h2e, 1'b0);
      end
      $display("test done");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    for (k = 0; k < 4; k = k + 1) smp[k] = 0;
    for (k = 0; k < 4; k = k + 1) v[k] = $random(seed) & 16'h7fff;
    repeat (20) @(posedge mclk);
    arst_n <= 1;
    repeat (3) @(posedge mclk);
    chk(0, 0, 0, 0);
    put(v[0], 16'h8000 | v[1], v[2], v[3]);
    put(v[1], v[1], 16'h8000 | v[3], 16'h8001);
    chk(v[0], 16'h8000 | v[1], 16'h8000 | v[3], 0);
    conv <= 1;
    adpt <= 1;
    repeat (3) @(posedge mclk);
    put(16'hffff, v[2], 16'h8000, v[0]);
    chk(0, v[2], 16'h8000, v[0]);
    wd <= $random(seed);
    u_host.acc(8'h28, 1'b1);
    u_host.acc(8'h2d, 1'b1);
    chk(0, v[2], 16'h8000, v[0]);
    en <= 0;
    put(16'h1234, 16'h0001, 16'h0002, 16'h0003);
    en <= 1;
    chk(0, v[2], 16'h8000, v[0]);
    srst <= 1;
    fork
      begin @(posedge mclk); srst <= 0; end
      chk(0, 0, 0, 0);
    join
    conv <= 0;
    repeat (3) @(posedge mclk);
    put(v[3], 0, 0, 0);
    put(v[2], 0, 0, 0);
    chk(v[3], 0, 0, 0);
    pres <= 0;
    repeat (3) @(posedge mclk);
    pres <= 1;
    repeat (3) @(posedge mclk);
    put(v[1], 0, 0, 0);
    chk(v[1], 0, 0, 0);
    arst_n <= 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1;
    repeat (3) @(posedge mclk);
    chk(0, 0, 0, 0);
    print_verdict;
  end
endmodule // arr_adc_result_registers_tb
